// *** rtl/sdrc_device.sv ***
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module sdrc_device import sdrc_pkg::*; #(
  parameter int NUM_BANKS = 2
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic sys_rst,
  // memory pins
  sdrc_if.dev pins,
  // observed state
  output logic [11:0] mode_code,
  output logic [5:0] bank_state
);
  // all state of the device
  typedef struct packed {
    sdrc_bank_type [1:0] bank;
    logic [1:0][10:0] row;
    logic [11:0] mode;
    logic busy;
    logic bsel;
    logic wr;
    logic [7:0] base;
    logic [8:0] idx;
    logic [8:0] len;
    logic [LAT_PIPE-1:0] rvld;
    logic [LAT_PIPE-1:0][15:0] rdat;
    logic [15:0] dout;
    logic oe;
  } sdrc_dev_state_type;

  sdrc_dev_state_type q; // registered state
  sdrc_dev_state_type d; // next state
  logic [15:0] mem [0:511]; // bank and column storage
  logic mem_we; // write beat this cycle
  logic [8:0] mem_a; // beat address
  logic [15:0] mem_wd; // merged write word
  sdrc_cmd_type cmd; // decoded command
  logic cmd_ok; // command taken this edge

  // elaboration check
  initial begin
    if (NUM_BANKS != 2) begin
      $error("only two banks are served");
    end
  end

  // burst length from the mode code
  function automatic logic [8:0] burst_len(input logic [2:0] code);
    logic [8:0] n;
    n = 9'h001;
    unique case (code)
      3'h1: n = 9'h002;
      3'h2: n = 9'h004;
      3'h3: n = 9'h008;
      BL_PAGE: n = 9'h100;
      default: n = 9'h001;
    endcase
    return n;
  endfunction

  // column of the current beat
  function automatic logic [7:0] beat_col(input logic [7:0] base, input logic [8:0] idx, input logic [8:0] len,
                                          input logic ilv);
    logic [7:0] mask;
    logic [7:0] sum;
    mask = 8'(len - 9'h001);
    sum = 8'(base + idx[7:0]);
    if (ilv && len != 9'h100) begin
      return base ^ (idx[7:0] & mask);
    end
    return (base & ~mask) | (sum & mask);
  endfunction

  // decode: clock gate level acts at once, not one edge late
  assign cmd = sdrc_cmd_type'({pins.ras_n, pins.cas_n, pins.we_n});
  assign cmd_ok = pins.cke && !pins.cs_n;

  // next-state logic
  always_comb begin
    logic go;
    logic both_idle;
    logic ap;
    logic [7:0] col;
    logic [15:0] rd_word;
    logic [2:0] lat;
    go = 1'b0;
    both_idle = (q.bank[0] == BK_IDLE) && (q.bank[1] == BK_IDLE);
    ap = pins.addr[AP_BIT];
    col = 8'h00;
    rd_word = 16'h0000;
    lat = q.mode[MODE_LAT_LSB +: 3];
    d = q;
    mem_we = 1'b0;
    mem_a = 9'h000;
    mem_wd = 16'h0000;
    d.rvld = {q.rvld[LAT_PIPE-2:0], 1'b0};
    d.rdat = {q.rdat[LAT_PIPE-2:0], 16'h0000};
    if (!pins.cke) begin
      // clock suspended or powered down: hold everything
      d = q;
    end else begin
      go = q.busy;
      if (cmd_ok) begin
        unique case (cmd)
          // burst stop: back to row active
          CMD_BST: begin
            if (q.busy) begin
              go = 1'b0;
              d.busy = 1'b0;
              d.bank[q.bsel] = BK_ACT;
            end
          end
          // column access, bits 8 and 9 unused
          CMD_READ, CMD_WRITE: begin
            if (q.busy && q.bsel != pins.addr[BANK_BIT]) begin
              // other bank's burst is cut short
              d.bank[q.bsel] = (q.bank[q.bsel] == BK_RDA || q.bank[q.bsel] == BK_WRA) ? BK_IDLE : BK_ACT;
            end
            go = 1'b1;
            d.busy = 1'b1;
            d.bsel = pins.addr[BANK_BIT];
            d.wr = (cmd == CMD_WRITE);
            d.base = pins.addr[7:0];
            d.idx = 9'h000;
            d.len = burst_len(q.mode[MODE_BL_LSB +: 3]);
            if (cmd == CMD_WRITE && q.mode[MODE_WM_LSB +: 3] == WM_SINGLE) begin
              d.len = 9'h001;
            end
            if (cmd == CMD_READ) begin
              d.bank[pins.addr[BANK_BIT]] = ap ? BK_RDA : BK_RD;
            end else begin
              d.bank[pins.addr[BANK_BIT]] = ap ? BK_WRA : BK_WR;
            end
          end
          // row open on an idle bank
          CMD_ACT: begin
            if (q.bank[pins.addr[BANK_BIT]] == BK_IDLE) begin
              d.bank[pins.addr[BANK_BIT]] = BK_ACT;
              d.row[pins.addr[BANK_BIT]] = pins.addr[10:0];
            end
          end
          // close one bank or both
          CMD_PRE: begin
            if (ap) begin
              d.bank[0] = BK_IDLE;
              d.bank[1] = BK_IDLE;
              go = 1'b0;
              d.busy = 1'b0;
            end else begin
              d.bank[pins.addr[BANK_BIT]] = BK_IDLE;
              if (q.busy && q.bsel == pins.addr[BANK_BIT]) begin
                go = 1'b0;
                d.busy = 1'b0;
              end
            end
          end
          // refresh changes no bank state
          CMD_REF: begin
            d.bank = q.bank;
          end
          // mode load with both banks idle
          CMD_MRS: begin
            if (both_idle) begin
              d.mode = pins.addr;
            end
          end
          // no-op
          CMD_NOP: begin
            d.bank = q.bank;
          end
        endcase
      end
      // one beat of the running burst
      if (go) begin
        col = beat_col(d.base, d.idx, d.len, q.mode[MODE_BT_BIT]);
        mem_a = {d.bsel, col};
        rd_word = mem[mem_a];
        if (d.wr) begin
          mem_we = 1'b1;
          mem_wd[7:0] = pins.dqm[0] ? rd_word[7:0] : pins.dq[7:0];
          mem_wd[15:8] = pins.dqm[1] ? rd_word[15:8] : pins.dq[15:8];
        end else begin
          d.rvld[0] = 1'b1;
          d.rdat[0] = rd_word;
        end
        d.idx = 9'(d.idx + 9'h001);
        if (d.idx == d.len) begin
          // burst done; auto-close banks go idle
          d.busy = 1'b0;
          unique case (d.bank[d.bsel])
            BK_RDA, BK_WRA: d.bank[d.bsel] = BK_IDLE;
            default: d.bank[d.bsel] = BK_ACT;
          endcase
        end
      end
      // output register at the programmed latency
      if (lat <= 3'h1) begin
        d.oe = go && !d.wr;
        d.dout = rd_word;
      end else begin
        d.oe = q.rvld[lat - 3'h2];
        d.dout = q.rdat[lat - 3'h2];
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage array
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_a] <= mem_wd;
    end
  end

  // pin and status outputs
  assign pins.dq_dev_out = q.dout;
  assign pins.dq_dev_oe = q.oe;
  assign mode_code = q.mode;
  assign bank_state = {q.bank[1], q.bank[0]};
endmodule
`default_nettype wire

// *** shared/sdrc_pkg.sv ***
// Notes on behaviour
// - rising clock gate revives inputs without edge
// - controller idles both banks before clock gate low
// - commands decode from strobes, top address bits
// - read with bit high enters read-then-close
// - write with bit high enters write-then-close
// - column commands ignore address bits 8, 9
// - each bank tracks six states independently; a read or write on one bank also ends the other bank's running burst
// - clock gate, byte masks high 100 us first
// - then close both banks
// - two refreshes and one mode load needed
// - mode load may precede the refreshes
// - mode load captures all twelve address bits
// - mode code: options, latency, ordering, length
// - mode load only with both banks idle
// - two cycles gap after mode load
// - first read word after programmed latency
// - burst columns generated internally
// - burst length 1, 2, 4, 8 or page
// - write option 001 stores single word
// - ordering bit: sequential 0, interleaved 1
package sdrc_pkg;
  // bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int COL_W = 8;
  // address field positions
  localparam int BANK_BIT = 11;
  localparam int AP_BIT = 10;
  // mode code fields
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_LAT_LSB = 4;
  localparam int MODE_WM_LSB = 9;
  localparam logic [2:0] WM_SINGLE = 3'h1;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [11:0] MODE_INIT = 12'h020;
  // timing
  localparam int CLK_MHZ = 10;
  localparam int INIT_TIME_US = 100;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  localparam int MRS_GAP_CYCLES = 2;
  localparam int REF_GAP_CYCLES = 8;
  localparam int LAT_PIPE = 6;
  // controller register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_PWR = 8'h14;
  // command code {ras_n, cas_n, we_n} with select low
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
    CMD_WRITE = 3'h4, CMD_READ = 3'h5, CMD_BST = 3'h6, CMD_NOP = 3'h7
  } sdrc_cmd_type;
  // bank state, gray along idle, active, read
  typedef enum logic [2:0] {
    BK_IDLE = 3'h0, BK_ACT = 3'h1, BK_RD = 3'h3, BK_RDA = 3'h2,
    BK_WR = 3'h5, BK_WRA = 3'h4
  } sdrc_bank_type;
  // controller sequence
  typedef enum logic [2:0] {
    CS_WAIT = 3'h0, CS_PALL = 3'h1, CS_REF = 3'h3, CS_MRS = 3'h2,
    CS_GAP = 3'h6, CS_RUN = 3'h7
  } sdrc_ctl_type;
endpackage

// *** shared/sdrc_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface sdrc_if;
  // command pins
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [11:0] addr;
  logic [1:0] dqm;
  // data pin halves and resolved level
  logic [15:0] dq_host_out;
  logic dq_host_oe;
  logic [15:0] dq_dev_out;
  logic dq_dev_oe;
  logic [15:0] dq;
  // resolve the shared data wire
  assign dq = dq_host_oe ? dq_host_out : (dq_dev_oe ? dq_dev_out : 16'h0000);
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, addr, dqm, dq_host_out, dq_host_oe, input dq);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, addr, dqm, dq, output dq_dev_out, dq_dev_oe);
endinterface
`default_nettype wire

// *** rtl/sdrc_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
module sdrc_ctrl import sdrc_pkg::*; #(
  parameter int REF_COUNT = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // memory pins
  sdrc_if.ctrl pins
);
  // all state of the controller
  typedef struct packed {
    sdrc_ctl_type st;
    logic [9:0] cnt;
    logic [3:0] refs;
    logic [2:0] cmd;
    logic cs_n;
    logic [11:0] addr;
    logic [11:0] areg;
    logic [15:0] wdata;
    logic oe;
    logic cke;
    logic pwr_req;
    logic [1:0] open;
    logic [11:0] mode;
    logic [3:0] rcnt;
    logic [15:0] rdata;
    logic [31:0] rd_out;
  } sdrc_ctl_state_type;

  sdrc_ctl_state_type q; // registered state
  sdrc_ctl_state_type d; // next state

  // elaboration check
  initial begin
    if (REF_COUNT < 2 || REF_COUNT > 15) begin
      $error("refresh count out of range");
    end
  end

  // next-state logic
  always_comb begin
    logic ready;
    logic [2:0] c;
    ready = (q.st == CS_RUN) && q.cke && (q.cnt == 10'h000);
    c = reg_wdata[2:0];
    d = q;
    d.cmd = CMD_NOP;
    d.rd_out = 32'h0000_0000;
    if (q.cnt != 10'h000) begin
      d.cnt = 10'(q.cnt - 10'h001);
    end
    if (q.rcnt != 4'h0) begin
      d.rcnt = 4'(q.rcnt - 4'h1);
      if (q.rcnt == 4'h1) begin
        d.rdata = pins.dq;
      end
    end
    unique case (q.st)
      // power-on hold with gate and masks high
      CS_WAIT: begin
        if (q.cnt == 10'h000) begin
          d.st = CS_PALL;
        end
      end
      // close both banks
      CS_PALL: begin
        d.cmd = CMD_PRE;
        d.addr = 12'h400;
        d.open = 2'b00;
        d.st = CS_REF;
        d.cnt = 10'(REF_GAP_CYCLES);
      end
      // refreshes
      CS_REF: begin
        if (q.cnt == 10'h000) begin
          d.cmd = CMD_REF;
          d.refs = 4'(q.refs + 4'h1);
          d.cnt = 10'(REF_GAP_CYCLES);
          if (4'(q.refs + 4'h1) == 4'(REF_COUNT)) begin
            d.st = CS_MRS;
          end
        end
      end
      // mode load, both banks idle here
      CS_MRS: begin
        if (q.cnt == 10'h000) begin
          d.cmd = CMD_MRS;
          d.addr = MODE_INIT;
          d.mode = MODE_INIT;
          d.cnt = 10'(MRS_GAP_CYCLES);
          d.st = CS_GAP;
        end
      end
      // wait after mode load
      CS_GAP: begin
        if (q.cnt == 10'h000) begin
          d.st = CS_RUN;
        end
      end
      // software commands
      CS_RUN: begin
        if (reg_wr && reg_addr == REG_CMD && ready) begin
          if (!((c == CMD_MRS || c == CMD_REF) && q.open != 2'b00)) begin
            d.cmd = c;
            d.addr = q.areg;
            unique case (sdrc_cmd_type'(c))
              CMD_ACT: d.open[q.areg[BANK_BIT]] = 1'b1;
              CMD_PRE: begin
                if (q.areg[AP_BIT]) begin
                  d.open = 2'b00;
                end else begin
                  d.open[q.areg[BANK_BIT]] = 1'b0;
                end
                d.oe = 1'b0;
              end
              CMD_WRITE: begin
                d.oe = 1'b1;
                if (q.areg[AP_BIT]) begin
                  d.open[q.areg[BANK_BIT]] = 1'b0;
                end
              end
              CMD_READ: begin
                d.oe = 1'b0;
                // capture one edge after the first word appears; latency 0 acts as 1
                d.rcnt = (q.mode[MODE_LAT_LSB +: 3] <= 3'h1) ? 4'h2 : 4'(q.mode[MODE_LAT_LSB +: 3] + 3'h1);
                if (q.areg[AP_BIT]) begin
                  d.open[q.areg[BANK_BIT]] = 1'b0;
                end
              end
              CMD_MRS: begin
                d.mode = q.areg;
                d.cnt = 10'(MRS_GAP_CYCLES);
              end
              CMD_BST: d.oe = 1'b0;
              default: d.oe = q.oe;
            endcase
          end
        end
        // gate low only with both banks idle
        d.cke = !(q.pwr_req && q.open == 2'b00 && q.rcnt == 4'h0);
      end
      default: d.st = CS_WAIT;
    endcase
    // deselect between commands, so the power-on wait shows no select
    d.cs_n = (d.cmd == CMD_NOP);
    // register writes and reads
    if (reg_wr && reg_addr == REG_ADDR) begin
      d.areg = reg_wdata[11:0];
    end
    if (reg_wr && reg_addr == REG_WDATA) begin
      d.wdata = reg_wdata[15:0];
    end
    if (reg_wr && reg_addr == REG_PWR) begin
      d.pwr_req = reg_wdata[0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_ADDR: d.rd_out = {20'h00000, q.areg};
        REG_WDATA: d.rd_out = {16'h0000, q.wdata};
        REG_RDATA: d.rd_out = {16'h0000, q.rdata};
        REG_STATUS: d.rd_out = {26'h0, q.rcnt != 4'h0, q.cke, q.open, ready, q.st == CS_RUN};
        REG_PWR: d.rd_out = {31'h0, q.pwr_req};
        default: d.rd_out = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= CS_WAIT;
      q.cnt <= 10'(INIT_CYCLES);
      q.cke <= 1'b1;
      q.cs_n <= 1'b1;
      q.cmd <= CMD_NOP;
      q.mode <= MODE_INIT;
    end else begin
      q <= d;
    end
  end

  // pins and read data
  assign pins.cke = q.cke;
  assign pins.cs_n = q.cs_n;
  assign {pins.ras_n, pins.cas_n, pins.we_n} = q.cmd;
  assign pins.addr = q.addr;
  assign pins.dqm = (q.st == CS_RUN) ? 2'b00 : 2'b11;
  assign pins.dq_host_out = q.wdata;
  assign pins.dq_host_oe = q.oe;
  assign reg_rdata = q.rd_out;
endmodule
`default_nettype wire

// *** verif/sdrc_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module sdrc_properties import sdrc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic [1:0] dqm,
  // data wire enables
  input wire logic dq_host_oe,
  input wire logic dq_dev_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // command taken this edge
  logic sel;
  logic [2:0] code;
  assign sel = cke && !cs_n;
  assign code = {ras_n, cas_n, we_n};
  // cycles since reset, saturating
  logic [10:0] cnt_q;
  // open row per bank, seen from the pins
  logic [1:0] open_q;
  // refreshes seen, saturating
  logic [1:0] refs_q;
  // any command seen yet
  logic seen_q;
  // read latency last loaded
  logic [2:0] lat_q;
  // track pin history
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 11'h000;
      open_q <= 2'h0;
      refs_q <= 2'h0;
      seen_q <= 1'b0;
      lat_q <= 3'h2;
    end else begin
      if (cnt_q != 11'h7ff) cnt_q <= cnt_q + 11'h001;
      if (sel) seen_q <= 1'b1;
      if (sel && code == CMD_REF && refs_q != 2'h3) refs_q <= refs_q + 2'h1;
      if (sel && code == CMD_MRS) lat_q <= addr[6:4];
      if (sel && code == CMD_ACT) open_q[addr[11]] <= 1'b1;
      // close one bank or both
      if (sel && code == CMD_PRE) open_q <= addr[10] ? 2'h0 : (addr[11] ? {1'b0, open_q[0]} : {open_q[1], 1'b0});
    end
  end
  // pins idle or no-op
  sequence s_quiet;
    cs_n || code == CMD_NOP;
  endsequence
  // a mode load taken
  sequence s_mode;
    sel && code == CMD_MRS;
  endsequence
  property p_init_hold;
    int'(cnt_q) < INIT_CYCLES |-> cke && dqm == 2'h3 && cs_n;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("pins not held during power-on wait");
  property p_first_close;
    sel && !seen_q |-> code == CMD_PRE && addr[10];
  endproperty
  a_first_close: assert property (p_first_close) else $error("first command is not close-all");
  property p_refresh_count;
    sel && code == CMD_ACT |-> refs_q >= 2'h2;
  endproperty
  a_refresh_count: assert property (p_refresh_count) else $error("row opened before two refreshes");
  property p_mode_idle;
    s_mode |-> open_q == 2'h0;
  endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("mode load with a bank open");
  property p_mode_gap;
    s_mode |=> s_quiet ##1 s_quiet;
  endproperty
  a_mode_gap: assert property (p_mode_gap) else $error("command too soon after mode load");
  property p_cmd_single;
    sel && code != CMD_NOP |=> s_quiet;
  endproperty
  a_cmd_single: assert property (p_cmd_single) else $error("command held over two edges");
  property p_refresh_idle;
    sel && code == CMD_REF |-> open_q == 2'h0;
  endproperty
  a_refresh_idle: assert property (p_refresh_idle) else $error("refresh with a bank open");
  property p_power_idle;
    $fell(cke) |-> open_q == 2'h0;
  endproperty
  a_power_idle: assert property (p_power_idle) else $error("clock gate dropped with a bank open");
  property p_read_latency;
    sel && code == CMD_READ && lat_q == 3'h2 |-> ##2 dq_dev_oe;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read word not on time");
  property p_bus_single;
    !(dq_host_oe && dq_dev_oe);
  endproperty
  a_bus_single: assert property (p_bus_single) else $error("both ends drive the data wire");
endmodule
`default_nettype wire

// *** verif/test_sdrc_two_bank_command_core.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_sdrc_two_bank_command_core import sdrc_pkg::*;;
  // clock, reset, register port
  logic clk;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  // device observation
  logic [11:0] mode_code;
  logic [5:0] bank_state;
  // bookkeeping
  int num_errors;
  int tests_run;
  int cycles = 0;
  logic [31:0] rv;
  sdrc_if pins_if();
  sdrc_ctrl sdrc_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins_if));
  sdrc_device sdrc_device_inst (.clk(clk), .sys_rst(sys_rst), .pins(pins_if), .mode_code(mode_code),
    .bank_state(bank_state));
  sdrc_properties sdrc_properties_inst (.clk(clk), .sys_rst(sys_rst), .cke(pins_if.cke), .cs_n(pins_if.cs_n),
    .ras_n(pins_if.ras_n), .cas_n(pins_if.cas_n), .we_n(pins_if.we_n), .addr(pins_if.addr), .dqm(pins_if.dqm),
    .dq_host_oe(pins_if.dq_host_oe), .dq_dev_oe(pins_if.dq_dev_oe));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // report and stop
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // register read, data in the next cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // issue a command, then compare both banks
  task automatic cmd(input logic [11:0] a, input logic [2:0] c, input sdrc_bank_type b1, input sdrc_bank_type b0);
    wr(REG_ADDR, {20'h00000, a});
    wr(REG_CMD, {29'h0, c});
    repeat (3) @(posedge clk);
    #1 check({26'h0, bank_state}, {26'h0, b1, b0});
  endtask
  // wait for power-on sequence
  task automatic t_init();
    rv = 32'h0;
    for (int i = 0; i < 1500 && rv[0] !== 1'b1; i++) rd(REG_STATUS, rv);
    check({31'h0, rv[0]}, 32'h1);
    check({20'h0, mode_code}, {20'h0, MODE_INIT});
    check({26'h0, bank_state}, 32'h0);
  endtask
  // load page bursts, then write, stop, read back
  task automatic t_write_read();
    cmd(12'h027, CMD_MRS, BK_IDLE, BK_IDLE);
    check({20'h0, mode_code}, 32'h027);
    check({29'h0, mode_code[6:4]}, 32'h2);
    wr(REG_WDATA, 32'ha5c3);
    cmd(12'h000, CMD_ACT, BK_IDLE, BK_ACT);
    cmd(12'h010, CMD_WRITE, BK_IDLE, BK_WR);
    cmd(12'h000, CMD_BST, BK_IDLE, BK_ACT);
    cmd(12'h310, CMD_READ, BK_IDLE, BK_RD);
    rd(REG_RDATA, rv);
    check(rv, 32'ha5c3);
  endtask
  // banks move one at a time, but the bank 1 read also cuts bank 0's burst back to row active
  task automatic t_two_banks();
    cmd(12'h800, CMD_ACT, BK_ACT, BK_RD);
    cmd(12'hc00, CMD_READ, BK_RDA, BK_ACT);
    cmd(12'h000, CMD_PRE, BK_RDA, BK_IDLE);
    cmd(12'h400, CMD_PRE, BK_IDLE, BK_IDLE);
    cmd(12'h800, CMD_ACT, BK_ACT, BK_IDLE);
    cmd(12'hc20, CMD_WRITE, BK_WRA, BK_IDLE);
    cmd(12'h400, CMD_PRE, BK_IDLE, BK_IDLE);
  endtask
  // no-op and refresh keep states
  task automatic t_idle_cmds();
    cmd(12'h000, CMD_NOP, BK_IDLE, BK_IDLE);
    cmd(12'h000, CMD_REF, BK_IDLE, BK_IDLE);
  endtask
  // single writes, burst lengths, interleaved read seen on the data wire
  task automatic t_bursts();
    logic [15:0] exp_w [4] = '{16'h0b01, 16'h0b00, 16'h0b03, 16'h0b02};
    cmd(12'h223, CMD_MRS, BK_IDLE, BK_IDLE);
    cmd(12'h000, CMD_ACT, BK_IDLE, BK_ACT);
    for (int i = 0; i < 4; i++) begin
      wr(REG_WDATA, 32'h0b00 + i);
      cmd(12'h040 + 12'(i), CMD_WRITE, BK_IDLE, BK_ACT);
    end
    cmd(12'h040, CMD_READ, BK_IDLE, BK_RD);
    rd(REG_RDATA, rv);
    check(rv, 32'h0b00);
    cmd(12'h400, CMD_PRE, BK_IDLE, BK_IDLE);
    cmd(12'h03a, CMD_MRS, BK_IDLE, BK_IDLE);
    cmd(12'h000, CMD_ACT, BK_IDLE, BK_ACT);
    wr(REG_ADDR, 32'h041);
    wr(REG_CMD, {29'h0, CMD_READ});
    repeat (2) @(posedge clk);
    // latency three: nothing on the wire yet
    #1 check({31'h0, pins_if.dq_dev_oe}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1 check({16'h0, pins_if.dq}, {16'h0, exp_w[i]});
    end
    @(posedge clk);
    // four words, then back to row active
    #1 check({26'h0, bank_state}, {26'h0, BK_IDLE, BK_ACT});
    rd(REG_RDATA, rv);
    check(rv, 32'h0b01);
    cmd(12'h400, CMD_PRE, BK_IDLE, BK_IDLE);
  endtask
  // power-down, wake, register map
  task automatic t_regs_power();
    wr(REG_PWR, 32'h1);
    repeat (4) @(posedge clk);
    rd(REG_STATUS, rv);
    check({31'h0, rv[4]}, 32'h0);
    wr(REG_PWR, 32'h0);
    repeat (4) @(posedge clk);
    rd(REG_STATUS, rv);
    check({31'h0, rv[4]}, 32'h1);
    cmd(12'h800, CMD_ACT, BK_ACT, BK_IDLE);
    rd(REG_ADDR, rv);
    check(rv, 32'h800);
    rd(8'h20, rv);
    check(rv, 32'h0);
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      close_out();
    end
  end
  // main sequence
  initial begin
    num_errors = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_init();
    t_write_read();
    t_two_banks();
    t_idle_cmds();
    t_bursts();
    t_regs_power();
    close_out();
  end
endmodule
`default_nettype wire
